// ===== shared/prc_defs.svh
// Offsets, field positions and reset values for the pump remote control
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

// -------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------
`define PRC_OFS_CTRL 8'h00
`define PRC_OFS_CMD 8'h04
`define PRC_OFS_SPEED 8'h08
`define PRC_OFS_TEMP 8'h0C
`define PRC_OFS_STATUS 8'h10
`define PRC_OFS_BASE 8'h14

// -------------------------------------------------------------
// Control register fields
// -------------------------------------------------------------
`define PRC_CTRL_SERIAL_BIT 0
`define PRC_CTRL_ALT_EN_BIT 1
`define PRC_CTRL_ALT_SEL_BIT 2
`define PRC_CTRL_RST 3'h0

// -------------------------------------------------------------
// Command register fields (write-one pulses)
// -------------------------------------------------------------
`define PRC_CMD_START_BIT 0
`define PRC_CMD_STOP_BIT 1
`define PRC_CMD_CLR_BIT 2

// -------------------------------------------------------------
// Speed and temperature settings
// -------------------------------------------------------------
`define PRC_SPEED_NORM_RST 16'h0000
`define PRC_SPEED_ALT_RST 16'h0000
`define PRC_TEMP_SET_RST 12'h000
`define PRC_TEMP_BAND_RST 8'h0A
// Break contacts rest closed so a held reset still reads as stopped and healthy
`define PRC_CONT_RST 12'h122

`endif

// ===== shared/prc_pkg.sv
// Types shared by the pump remote control block
package prc_pkg;

   // Contact pins from the host, active high means the contact is closed
   typedef struct packed {
      logic start;
      logic stop;
      logic fault_reset;
      logic hold;
      logic hold_en;
      logic port_sel;
      logic alt_sel;
   } prc_pins_t;

   // Status from the rest of the controller, same clock
   typedef struct packed {
      logic levitated;
      logic supply_ok;
      logic at_rated;
      logic stopped;
      logic fault;
      logic fault_pump;
      logic warn;
   } prc_stat_t;

   // Relay drives, high closes the contact
   typedef struct packed {
      logic levitate;
      logic accel;
      logic rated_mk;
      logic rated_bk;
      logic brake;
      logic fault_mk;
      logic fault_bk;
      logic warn;
      logic par_sel;
      logic band_mk;
      logic band_bk;
      logic alt;
   } prc_contacts_t;

   typedef enum logic [4:0] {
      PRC_IDLE  = 5'h01,
      PRC_WAIT  = 5'h02,
      PRC_ACCEL = 5'h04,
      PRC_RATED = 5'h08,
      PRC_BRAKE = 5'h10
   } prc_state_t;

endpackage

// ===== rtl/prc_remote_ctrl.sv
// Remote contact interface, rotor sequencing and thermal control of a pump controller
//
// Function
// - Start with hold closed accelerates at once
// - Start with hold open waits for close
// - Hold opening while running brakes to stop
// - Re-closing hold never restarts; start needed
// - Separate alternate rated speed setting kept
// - Speed choice from pin or serial port
// - Levitation contact closed while bearing levitates and supply is ok
// - Spin-up contact closed while accelerating
// - Rated contacts make/break at rated speed
// - Braking contact closed while braking
// - Fault make closes, break opens on fault
// - Warning contact closed during warning
// - Parallel-select contact closed when parallel active
// - Status outputs work for either port
// - Alternate-speed contact when enabled and selected
// - Thermal unit runs whenever powered
// - Pump-originated fault stops thermal unit
// - Below setpoint: heater on, valve off
// - Above setpoint: heater off, valve on
// - Hold inputs effective with serial port active
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "prc_defs.svh"

module prc_remote_ctrl (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Host contacts and controller status
   input wire prc_pkg::prc_pins_t i_pins,
   input wire prc_pkg::prc_stat_t i_stat,
   input wire logic [11:0] i_base_temp,
   // Drive commands and relays
   output logic o_accel_cmd,
   output logic o_brake_cmd,
   output logic [15:0] o_speed_target,
   output logic o_heater,
   output logic o_valve,
   output prc_pkg::prc_contacts_t o_contacts
);
   import prc_pkg::*;

   // -------------------------------------------------------------
   // Reset release and pin synchronisers
   // -------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [6:0] pin_raw;
   logic [6:0] pin_s1_q;
   logic [6:0] pin_s2_q;
   logic start_prev_q;
   prc_pins_t pin;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   assign pin_raw = i_pins;
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_sync
         always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
               pin_s1_q[gi] <= 1'b0;
               pin_s2_q[gi] <= 1'b0;
            end else begin
               pin_s1_q[gi] <= pin_raw[gi];
               pin_s2_q[gi] <= pin_s1_q[gi];
            end
         end
      end
   endgenerate
   assign pin = prc_pins_t'(pin_s2_q);

   // -------------------------------------------------------------
   // APB register file
   // -------------------------------------------------------------
   logic [2:0] ctrl_q, ctrl_d;
   logic [15:0] spd_norm_q, spd_norm_d;
   logic [15:0] spd_alt_q, spd_alt_d;
   logic [11:0] temp_set_q, temp_set_d;
   logic [7:0] temp_band_q, temp_band_d;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic cmd_start;
   logic cmd_stop;
   logic cmd_clr;
   prc_state_t state_q, state_d;
   prc_contacts_t cont_q, cont_d;
   logic fault_q, fault_d;
   logic heater_q, heater_d;
   logic valve_q, valve_d;

   assign wr_en = i_psel && i_penable && i_pwrite;
   assign rd_en = i_psel && i_penable && !i_pwrite;
   assign o_pready = 1'b1;

   always_comb begin
      if (i_paddr == `PRC_OFS_CTRL) begin
         addr_ok = 1'b1;
      end else if (i_paddr == `PRC_OFS_CMD) begin
         addr_ok = 1'b1;
      end else if (i_paddr == `PRC_OFS_SPEED) begin
         addr_ok = 1'b1;
      end else if (i_paddr == `PRC_OFS_TEMP) begin
         addr_ok = 1'b1;
      end else if (i_paddr == `PRC_OFS_STATUS) begin
         addr_ok = 1'b1;
      end else if (i_paddr == `PRC_OFS_BASE) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end
   // Unmapped addresses error in the access phase and change nothing
   assign o_pslverr = i_psel && i_penable && !addr_ok;

   // Serial commands are pulses and only steer the rotor from the serial port
   assign cmd_start = wr_en && (i_paddr == `PRC_OFS_CMD) && i_pwdata[`PRC_CMD_START_BIT];
   assign cmd_stop = wr_en && (i_paddr == `PRC_OFS_CMD) && i_pwdata[`PRC_CMD_STOP_BIT];
   assign cmd_clr = wr_en && (i_paddr == `PRC_OFS_CMD) && i_pwdata[`PRC_CMD_CLR_BIT];

   always_comb begin
      ctrl_d = ctrl_q;
      spd_norm_d = spd_norm_q;
      spd_alt_d = spd_alt_q;
      temp_set_d = temp_set_q;
      temp_band_d = temp_band_q;
      if (wr_en && i_paddr == `PRC_OFS_CTRL) begin
         ctrl_d = i_pwdata[2:0];
      end else if (wr_en && i_paddr == `PRC_OFS_SPEED) begin
         spd_norm_d = i_pwdata[15:0];
         spd_alt_d = i_pwdata[31:16];
      end else if (wr_en && i_paddr == `PRC_OFS_TEMP) begin
         temp_set_d = i_pwdata[11:0];
         temp_band_d = i_pwdata[23:16];
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `PRC_CTRL_RST;
         spd_norm_q <= `PRC_SPEED_NORM_RST;
         spd_alt_q <= `PRC_SPEED_ALT_RST;
         temp_set_q <= `PRC_TEMP_SET_RST;
         temp_band_q <= `PRC_TEMP_BAND_RST;
      end else begin
         ctrl_q <= ctrl_d;
         spd_norm_q <= spd_norm_d;
         spd_alt_q <= spd_alt_d;
         temp_set_q <= temp_set_d;
         temp_band_q <= temp_band_d;
      end
   end

   always_comb begin
      o_prdata = 32'h0;
      if (rd_en && i_paddr == `PRC_OFS_CTRL) begin
         o_prdata = {29'h0, ctrl_q};
      end else if (rd_en && i_paddr == `PRC_OFS_SPEED) begin
         o_prdata = {spd_alt_q, spd_norm_q};
      end else if (rd_en && i_paddr == `PRC_OFS_TEMP) begin
         o_prdata = {8'h0, temp_band_q, 4'h0, temp_set_q};
      end else if (rd_en && i_paddr == `PRC_OFS_STATUS) begin
         o_prdata = {8'h0, fault_q, heater_q, valve_q, state_q, 4'h0, cont_q};
      end else if (rd_en && i_paddr == `PRC_OFS_BASE) begin
         o_prdata = {20'h0, i_base_temp};
      end
   end

   // -------------------------------------------------------------
   // Port selection and command sources
   // -------------------------------------------------------------
   logic par_active;
   logic hold_ok;
   logic start_req;
   logic stop_req;
   logic alt_sel;
   logic alt_on;

   // Closed select pin forces the parallel port whatever the mode bit says
   assign par_active = pin.port_sel || !ctrl_q[`PRC_CTRL_SERIAL_BIT];
   // Hold stays live on either port; open enable means no hold
   assign hold_ok = !pin.hold_en || pin.hold;
   assign start_req = par_active ? (pin.start && !start_prev_q) : cmd_start;
   assign stop_req = par_active ? pin.stop : cmd_stop;
   assign alt_sel = par_active ? pin.alt_sel : ctrl_q[`PRC_CTRL_ALT_SEL_BIT];
   assign alt_on = ctrl_q[`PRC_CTRL_ALT_EN_BIT] && alt_sel;

   // -------------------------------------------------------------
   // Rotor sequencer
   // -------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         PRC_IDLE: begin
            if (start_req && !fault_q) begin
               state_d = hold_ok ? PRC_ACCEL : PRC_WAIT;
            end
         end
         PRC_WAIT: begin
            if (stop_req || fault_q) begin
               state_d = PRC_IDLE;
            end else if (hold_ok) begin
               state_d = PRC_ACCEL;
            end
         end
         PRC_ACCEL: begin
            if (!hold_ok || stop_req || fault_q) begin
               state_d = PRC_BRAKE;
            end else if (i_stat.at_rated) begin
               state_d = PRC_RATED;
            end
         end
         PRC_RATED: begin
            if (!hold_ok || stop_req || fault_q) begin
               state_d = PRC_BRAKE;
            end
         end
         PRC_BRAKE: begin
            // Hold closing again is ignored here; a fresh start is needed
            if (start_req && hold_ok && !fault_q) begin
               state_d = PRC_ACCEL;
            end else if (i_stat.stopped) begin
               state_d = PRC_IDLE;
            end
         end
         default: begin
            state_d = PRC_IDLE;
         end
      endcase
   end

   // Fault latch: a new fault in the clear cycle wins
   always_comb begin
      fault_d = fault_q;
      if (cmd_clr || pin.fault_reset) begin
         fault_d = 1'b0;
      end
      if (i_stat.fault) begin
         fault_d = 1'b1;
      end
   end

   // -------------------------------------------------------------
   // Thermal unit
   // -------------------------------------------------------------
   logic tmu_run;
   logic [12:0] temp_diff;
   logic in_band;

   // Runs while powered, stops only for a fault of the pump itself
   assign tmu_run = i_stat.supply_ok && !(fault_q && i_stat.fault_pump);
   assign temp_diff = (i_base_temp >= temp_set_q) ?
                      {1'b0, i_base_temp - temp_set_q} : {1'b0, temp_set_q - i_base_temp};
   assign in_band = temp_diff <= {5'h0, temp_band_q};

   always_comb begin
      heater_d = heater_q;
      valve_d = valve_q;
      if (!tmu_run) begin
         heater_d = 1'b0;
         valve_d = 1'b0;
      end else if (i_base_temp < temp_set_q) begin
         heater_d = 1'b1;
         valve_d = 1'b0;
      end else if (i_base_temp > temp_set_q) begin
         heater_d = 1'b0;
         valve_d = 1'b1;
      end
      // Equal temperature keeps both, avoiding relay chatter
   end

   // -------------------------------------------------------------
   // Contact flags, same on either port; only par_sel reports which port is active
   // -------------------------------------------------------------
   always_comb begin
      cont_d.levitate = i_stat.levitated && i_stat.supply_ok;
      cont_d.accel = (state_d == PRC_ACCEL);
      cont_d.rated_mk = (state_d == PRC_RATED);
      cont_d.rated_bk = (state_d != PRC_RATED);
      cont_d.brake = (state_d == PRC_BRAKE);
      cont_d.fault_mk = fault_d;
      cont_d.fault_bk = !fault_d;
      cont_d.warn = i_stat.warn;
      cont_d.par_sel = par_active;
      cont_d.band_mk = tmu_run && in_band;
      cont_d.band_bk = !(tmu_run && in_band);
      cont_d.alt = alt_on;
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= PRC_IDLE;
         fault_q <= 1'b0;
         heater_q <= 1'b0;
         valve_q <= 1'b0;
         cont_q <= `PRC_CONT_RST;
         start_prev_q <= 1'b0;
         o_speed_target <= 16'h0;
      end else begin
         state_q <= state_d;
         fault_q <= fault_d;
         heater_q <= heater_d;
         valve_q <= valve_d;
         cont_q <= cont_d;
         start_prev_q <= pin.start;
         o_speed_target <= alt_on ? spd_alt_q : spd_norm_q;
      end
   end

   assign o_contacts = cont_q;
   assign o_heater = heater_q;
   assign o_valve = valve_q;
   assign o_accel_cmd = cont_q.accel;
   assign o_brake_cmd = cont_q.brake;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   chk_wait_no_accel: assert property (
      (state_q == PRC_WAIT && !hold_ok && !stop_req && !fault_q) |=> state_q == PRC_WAIT)
      else $error("accelerated with hold open");
   chk_start_accel: assert property (
      (state_q == PRC_IDLE && start_req && hold_ok && !fault_q) |=> cont_q.accel)
      else $error("start with hold closed did not accelerate");
   chk_hold_brake: assert property (
      ((state_q == PRC_ACCEL || state_q == PRC_RATED) && !hold_ok) |=> state_q == PRC_BRAKE)
      else $error("hold open did not brake");
   chk_no_resume: assert property (
      (state_q == PRC_BRAKE && !start_req) |=> state_q != PRC_ACCEL)
      else $error("brake resumed without start");
   chk_rated_pair: assert property (
      cont_q.rated_mk != cont_q.rated_bk)
      else $error("rated contacts not complementary");
   chk_fault_pair: assert property (
      $rose(fault_q) |-> cont_q.fault_mk && !cont_q.fault_bk)
      else $error("fault contacts wrong");
   chk_heat_cold: assert property (
      (tmu_run && i_base_temp < temp_set_q) |=> heater_q && !valve_q)
      else $error("heater not on below setpoint");
   chk_cool_hot: assert property (
      (tmu_run && i_base_temp > temp_set_q) |=> !heater_q && valve_q)
      else $error("valve not on above setpoint");
   chk_equal_hold: assert property (
      (tmu_run && i_base_temp == temp_set_q) |=> $stable(heater_q) && $stable(valve_q))
      else $error("thermal outputs changed at setpoint");
   chk_tmu_stop: assert property (
      (fault_q && i_stat.fault_pump) |=> !heater_q && !valve_q)
      else $error("thermal unit kept running on pump fault");
   chk_par_sel: assert property (
      pin.port_sel |=> cont_q.par_sel)
      else $error("parallel select contact open");

   cov_start_run: cover property (start_req ##[1:20] state_q == PRC_RATED);
   cov_wait_hold: cover property (state_q == PRC_WAIT ##[1:20] state_q == PRC_ACCEL);
   cov_hold_stop: cover property (state_q == PRC_RATED ##1 state_q == PRC_BRAKE);
   cov_alt_speed: cover property (cont_q.alt && cont_q.rated_mk);

endmodule // prc_remote_ctrl

// ===== dv/prc_host_model.sv
// Host equipment model driving the remote contact inputs
`timescale 1ns/10ps
module prc_host_model (
   // Clock
   input wire logic i_clk,
   // Contact inputs of the device, 1 = closed
   output prc_pkg::prc_pins_t o_pins
);
   import prc_pkg::*;
   // Stop contact rests open and is pulsed like start; stops also come from hold and the command register
   prc_pins_t pins_q = '0;
   assign o_pins = pins_q;
   // Hold only matters with its enable contact closed; the host owns both
   task automatic hold(input logic en, input logic h);
      @(posedge i_clk);
      pins_q.hold_en <= en;
      pins_q.hold <= h;
   endtask
   task automatic port(input logic p);
      @(posedge i_clk);
      pins_q.port_sel <= p;
   endtask
   task automatic alt(input logic a);
      @(posedge i_clk);
      pins_q.alt_sel <= a;
   endtask
   // Presses last several cycles so the synchroniser cannot miss them
   task automatic pulse(input int b);
      @(posedge i_clk);
      pins_q[b] <= 1'b1;
      repeat (4) @(posedge i_clk);
      pins_q[b] <= 1'b0;
   endtask
endmodule // prc_host_model

// ===== dv/test_pump_remote_io_control.sv
// Self-checking testbench of the pump remote control block
`timescale 1ns/10ps
module test_pump_remote_io_control;
   import prc_pkg::*;
   typedef struct packed {
      logic [11:0] t;
      logic [2:0] hvb;
   } prc_row_t;
   logic i_clk = 0;
   logic i_rst_n = 0;
   logic psel = 0;
   logic pen = 0;
   logic pwr = 0;
   logic perr;
   logic pready;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic err;
   logic acc, brk, heat, valve;
   logic [15:0] spd;
   logic [11:0] temp = 12'h000;
   prc_pins_t pins;
   prc_stat_t stat = 7'h60;
   prc_contacts_t ct;
   int mismatches = 0;
   int n_tests = 0;
   prc_row_t rows [8] = '{'{12'h032, 3'b100}, '{12'h064, 3'b101}, '{12'h06E, 3'b011},
      '{12'h06F, 3'b010}, '{12'hFFF, 3'b010}, '{12'h064, 3'b011}, '{12'h05A, 3'b101},
      '{12'h059, 3'b100}};

   prc_remote_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(perr), .i_pins(pins), .i_stat(stat),
      .i_base_temp(temp), .o_accel_cmd(acc), .o_brake_cmd(brk), .o_speed_target(spd),
      .o_heater(heat), .o_valve(valve), .o_contacts(ct));
   prc_host_model host (.i_clk(i_clk), .o_pins(pins));

   initial begin
      forever #25 i_clk = ~i_clk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // Request held until pready is sampled high; only the watchdog ends a hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // Rotor state from the status register and the contacts that follow it
   task automatic see(input logic [4:0] s);
      tick(5);
      apb(0, 8'h10, 0);
      chk(rd[20:16], s);
      chk({ct.accel, ct.brake, ct.rated_mk, ct.rated_bk, acc, brk},
         {s[2], s[4], s[3], !s[3], s[2], s[4]});
   endtask

   initial begin
      #1000000;
      mismatches++;
      end_sim();
   end

   initial begin
      tick(2);
      chk({ct, heat, valve}, {12'h122, 2'b00});
      tick(2);
      i_rst_n <= 1'b1;
      tick(4);
      chk({ct.levitate, ct.rated_bk, ct.fault_bk}, 3'b111);
      apb(0, 8'h0C, 0);
      chk(rd, 32'h000A0000);
      $display("reset test done");
      apb(1, 8'h0C, 32'h000A0064);
      foreach (rows[i]) begin
         temp <= rows[i].t;
         tick(3);
         chk({heat, valve, ct.band_mk, ct.band_bk}, {rows[i].hvb, !rows[i].hvb[0]});
      end
      $display("thermal table done");
      stat <= 7'h66;
      tick(3);
      chk({ct.fault_mk, ct.fault_bk, heat, valve}, 4'b1000);
      stat <= 7'h60;
      host.pulse(6);
      tick(3);
      chk({acc, ct.fault_mk, heat}, 3'b011);
      host.pulse(4);
      tick(4);
      chk({ct.fault_mk, ct.fault_bk}, 2'b01);
      stat <= 7'h41;
      tick(3);
      chk({ct.levitate, heat, valve, ct.warn}, 4'b0001);
      stat <= 7'h20;
      tick(3);
      chk({ct.levitate, heat}, 2'b01);
      stat <= 7'h60;
      $display("fault test done");
      host.port(1);
      host.hold(1, 0);
      host.pulse(6);
      see(PRC_WAIT);
      chk(ct.par_sel, 1);
      host.hold(1, 1);
      see(PRC_ACCEL);
      stat <= 7'h70;
      see(PRC_RATED);
      host.hold(1, 0);
      see(PRC_BRAKE);
      stat <= 7'h60;
      host.hold(1, 1);
      see(PRC_BRAKE);
      host.pulse(6);
      see(PRC_ACCEL);
      host.hold(0, 0);
      see(PRC_ACCEL);
      host.hold(1, 0);
      see(PRC_BRAKE);
      stat <= 7'h68;
      see(PRC_IDLE);
      stat <= 7'h60;
      host.hold(1, 1);
      host.pulse(6);
      see(PRC_ACCEL);
      host.pulse(5);
      see(PRC_BRAKE);
      host.hold(1, 0);
      stat <= 7'h68;
      tick(8);
      stat <= 7'h60;
      $display("parallel rotor test done");
      host.port(0);
      apb(1, 8'h00, 1);
      apb(1, 8'h04, 1);
      see(PRC_WAIT);
      chk(ct.par_sel, 0);
      host.hold(1, 1);
      see(PRC_ACCEL);
      apb(1, 8'h04, 2);
      see(PRC_BRAKE);
      $display("serial rotor test done");
      apb(1, 8'h08, 32'h22221111);
      apb(1, 8'h00, 7);
      tick(3);
      chk({spd, ct.alt}, {16'h2222, 1'b1});
      apb(1, 8'h00, 3);
      tick(3);
      chk({spd, ct.alt}, {16'h1111, 1'b0});
      host.port(1);
      host.alt(1);
      apb(1, 8'h00, 2);
      tick(5);
      chk({spd, ct.alt}, {16'h2222, 1'b1});
      apb(1, 8'h00, 0);
      tick(3);
      chk({spd, ct.alt}, {16'h1111, 1'b0});
      apb(0, 8'hE0, 0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      chk(pready, 1'b1);
      $display("speed and bus test done");
      end_sim();
   end
endmodule // test_pump_remote_io_control
